// ==== verilog/amc_regs.vh ====
// Purpose: Constants for the converter mode and channel control block
// Assumes: 12-bit parallel data bus, bits 11..10 address a control word
// Notes:   Shared by the control block and its checker
// Function
// - Single conversion mode turns the conversion clock pin into a start strobe.
// - Falling start strobe edge holds all selected inputs and starts conversion.
// - In single conversion mode data available asserts once trigger met.
// - Trigger met when results written reach or exceed the configured trigger level.
// - Bit 2 of first word powers down when set; resets to zero.
// - Register writes, reads and FIFO reads still work while powered down.
// - Input select uses bits 7..3; bits 4..3 are channel select, reset zero.
// - Bits 6..5 reset to 0,1; bit 7 enables autoscan, reset zero.
// - Codes 00000 positive, 00001 negative, 00100 differential pair.
// - Code 10001 autoscans positive then negative; all else reserved.
// - Test bits 9..8 reset 00: normal, upper, mid-point, lower reference.
// - Test voltages let the host check connections and converter operation.
// - Second word at address 01 holds reset, clear, trigger, type, format bits.
// - Write data bits 11..10 address the word, bits 9..0 carry the value.
`ifndef AMC_REGS_VH
`define AMC_REGS_VH
// ==========================================
// Addresses
`define AMC_ADDR_CFG0    2'h0
`define AMC_ADDR_CFG1    2'h1
// ==========================================
// Field ranges
`define AMC_F_ADDR       11:10
`define AMC_F_VALUE      9:0
`define AMC_F_KEEP       9:2
`define AMC_F_CHAN       7:3
`define AMC_F_TEST       9:8
`define AMC_F_TRIG       3:2
// ==========================================
// First word fields
`define AMC_B_VREF       0
`define AMC_B_MODE       1
`define AMC_B_POWER      2
`define AMC_B_SCAN       7
`define AMC_CFG0_RESET   10'h020
// ==========================================
// Second word fields
`define AMC_B_RST        0
`define AMC_B_FIFO_CLR   1
`define AMC_B_DTYPE      4
`define AMC_B_DPOL       5
`define AMC_CFG1_RESET   10'h030
// ==========================================
// Channel codes, bits 7..3
`define AMC_CH_POS       5'h00
`define AMC_CH_NEG       5'h01
`define AMC_CH_DIFF      5'h04
`define AMC_CH_SCAN      5'h11
// ==========================================
// Test codes
`define AMC_TST_NORMAL   2'h0
`define AMC_TST_UPPER    2'h1
`define AMC_TST_MID      2'h2
`define AMC_TST_LOWER    2'h3
// ==========================================
// Trigger levels
`define AMC_TRIG_L0      5'h01
`define AMC_TRIG_L1      5'h04
`define AMC_TRIG_L2      5'h08
`define AMC_TRIG_L3      5'h0e
`endif

// ==== verilog/amc_sync.v ====
// Purpose: Two flip-flop synchroniser
// Assumes: Asynchronous input
// Notes:   First stage read only by second
`timescale 1ns/100ps
`default_nettype none
module amc_sync
(
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  // Data
  input  wire d,
  output reg  q
);
  reg meta;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/amc_control.v ====
// Purpose: Control words, conversion start, input and test selection
// Assumes: Write strobe is a one-cycle pulse in the CLK domain
// Notes:   Conversion pin sampled through a synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "amc_regs.vh"
module amc_control
(
  // Clock and reset
  input  wire        CLK,
  input  wire        RST_B,
  // Register port
  input  wire        WR_STB,
  input  wire        RD_STB,
  input  wire [11:0] WR_DATA,
  input  wire [1:0]  RD_ADDR,
  output reg  [9:0]  RD_DATA,
  // Conversion pin and FIFO side
  input  wire        CONVERSION_CLOCK_IN,
  input  wire        RESULT_WRITTEN,
  input  wire        OVERFLOW_IN,
  // Converter controls
  output wire        SAMPLE_HOLD,
  output wire        CONVERT_START,
  output wire        POWER_DOWN,
  output wire        SELECT_POSITIVE,
  output wire        SELECT_NEGATIVE,
  output wire        SELECT_DIFF,
  output reg         SCAN_NEGATIVE,
  output wire [1:0]  TEST_SELECT,
  output wire        EXT_REFERENCE,
  output wire        FIFO_CLEAR,
  output wire        DATA_AVAILABLE_OUT
);
  // ==========================================
  // Registers
  reg  [9:0] mode_channel_config;
  reg  [9:0] fifo_interface_config;
  reg        overflow;
  reg        conv_q;
  reg        clear_pulse;
  reg  [4:0] result_count;
  reg        trig_event;
  reg        avail_level;
  wire       conv_s;
  wire [1:0] wr_addr    = WR_DATA[`AMC_F_ADDR];
  wire [4:0] chan_code  = mode_channel_config[`AMC_F_CHAN];
  wire       single     = mode_channel_config[`AMC_B_MODE];
  wire       active     = ~mode_channel_config[`AMC_B_POWER];
  // Address decode shared by several processes
  wire       cfg1_write = WR_STB && wr_addr == `AMC_ADDR_CFG1;
  wire       cfg1_read  = RD_STB && RD_ADDR == `AMC_ADDR_CFG1;
  wire       soft_reset = cfg1_write && WR_DATA[`AMC_B_RST];
  wire       fifo_clr   = cfg1_write && WR_DATA[`AMC_B_FIFO_CLR];
  wire [4:0] trig_level = level_of(fifo_interface_config[`AMC_F_TRIG]);
  wire       avail_raw;
  // Edge detector resets low: no false fall after reset
  wire       conv_fall  = conv_q && !conv_s;

  function [4:0] level_of;
    input [1:0] code;
    begin
      case (code)
        2'h0:    level_of = `AMC_TRIG_L0;
        2'h1:    level_of = `AMC_TRIG_L1;
        2'h2:    level_of = `AMC_TRIG_L2;
        default: level_of = `AMC_TRIG_L3;
      endcase
    end
  endfunction

  // ==========================================
  // Pin synchroniser
  // Pin is asynchronous: two stages before any decode
  amc_sync u_sync
  (
    .clk   (CLK),
    .rst_b (RST_B),
    .d     (CONVERSION_CLOCK_IN),
    .q     (conv_s)
  );

  // ==========================================
  // Control words
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mode_channel_config   <= `AMC_CFG0_RESET;
      fifo_interface_config <= `AMC_CFG1_RESET;
    end
    // Soft reset wins over the write that carries it
    else if (soft_reset)
    begin
      mode_channel_config   <= `AMC_CFG0_RESET;
      fifo_interface_config <= `AMC_CFG1_RESET;
    end
    else if (WR_STB)
    begin
      // Writes accepted in power down too
      if (wr_addr == `AMC_ADDR_CFG0)
        mode_channel_config <= WR_DATA[`AMC_F_VALUE];
      else if (wr_addr == `AMC_ADDR_CFG1)
        // Bits 1..0 are strobes, never stored
        fifo_interface_config <= {WR_DATA[`AMC_F_KEEP], 2'h0};
    end
  end

  // ==========================================
  // Overflow flag: set wins over read clear
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      overflow <= 1'b0;
    else if (OVERFLOW_IN)
      overflow <= 1'b1;
    else if (soft_reset || cfg1_read)
      overflow <= 1'b0;
  end

  // ==========================================
  // Readback, also in power down
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      RD_DATA <= 10'h000;
    else if (RD_STB)
    begin
      case (RD_ADDR)
        `AMC_ADDR_CFG0: RD_DATA <= mode_channel_config;
        `AMC_ADDR_CFG1: RD_DATA <= {fifo_interface_config[`AMC_F_KEEP], overflow, 1'b0};
        // Reserved addresses read as zero
        default:        RD_DATA <= 10'h000;
      endcase
    end
  end

  // ==========================================
  // Start strobe edge
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      conv_q      <= 1'b0;
      clear_pulse <= 1'b0;
    end
    else
    begin
      conv_q      <= conv_s;
      clear_pulse <= soft_reset || fifo_clr;
    end
  end
  // Pin is a start strobe only in single mode; no conversion while powered down
  assign CONVERT_START = single && active && conv_fall;
  // All selected inputs enter hold together on the same edge
  assign SAMPLE_HOLD   = CONVERT_START;
  assign FIFO_CLEAR    = clear_pulse;

  // ==========================================
  // Input selection; reserved codes select nothing
  assign SELECT_POSITIVE = chan_code == `AMC_CH_POS  || chan_code == `AMC_CH_DIFF ||
                           (chan_code == `AMC_CH_SCAN && !SCAN_NEGATIVE);
  assign SELECT_NEGATIVE = chan_code == `AMC_CH_NEG  || chan_code == `AMC_CH_DIFF ||
                           (chan_code == `AMC_CH_SCAN && SCAN_NEGATIVE);
  assign SELECT_DIFF     = chan_code == `AMC_CH_DIFF;
  assign POWER_DOWN      = ~active;
  assign TEST_SELECT     = mode_channel_config[`AMC_F_TEST];
  assign EXT_REFERENCE   = mode_channel_config[`AMC_B_VREF];

  // Autoscan alternates per written result, positive first
  // Reserved codes park the phase on the positive input
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      SCAN_NEGATIVE <= 1'b0;
    else if (chan_code != `AMC_CH_SCAN || clear_pulse)
      SCAN_NEGATIVE <= 1'b0;
    else if (RESULT_WRITTEN)
      SCAN_NEGATIVE <= ~SCAN_NEGATIVE;
  end

  // ==========================================
  // Trigger counting
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      result_count <= 5'h00;
      trig_event   <= 1'b0;
    end
    else if (clear_pulse)
    begin
      result_count <= 5'h00;
      trig_event   <= 1'b0;
    end
    // At or above the level, so lowering the level never strands the count
    else if (RESULT_WRITTEN && result_count + 5'h01 >= trig_level)
    begin
      result_count <= 5'h00;
      // Only single mode raises data available
      trig_event   <= single;
    end
    else
    begin
      result_count <= RESULT_WRITTEN ? result_count + 5'h01 : result_count;
      trig_event   <= 1'b0;
    end
  end

  // Static type holds until next start or clear
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      avail_level <= 1'b0;
    else if (trig_event)
      avail_level <= 1'b1;
    else if (CONVERT_START || clear_pulse)
      avail_level <= 1'b0;
  end
  // Type bit picks pulse or level; polarity bit set means active high
  assign avail_raw = fifo_interface_config[`AMC_B_DTYPE] ? trig_event : avail_level;
  assign DATA_AVAILABLE_OUT = avail_raw ^ ~fifo_interface_config[`AMC_B_DPOL];
endmodule
`default_nettype wire

// ==== testbench/amc_control_props.sv ====
// Purpose: Assertions on the ports of amc_control
// Assumes: One clock domain, write strobe one cycle wide
// Notes:   Bound into every amc_control instance
`timescale 1ns/100ps
`default_nettype none
`include "amc_regs.vh"
module amc_control_props
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // Register port
  input wire logic        WR_STB,
  input wire logic        RD_STB,
  input wire logic [11:0] WR_DATA,
  input wire logic [1:0]  RD_ADDR,
  input wire logic [9:0]  RD_DATA,
  // Converter side
  input wire logic        CONVERSION_CLOCK_IN,
  input wire logic        SAMPLE_HOLD,
  input wire logic        CONVERT_START,
  input wire logic        POWER_DOWN,
  input wire logic        SELECT_POSITIVE,
  input wire logic        SELECT_NEGATIVE,
  input wire logic        SELECT_DIFF,
  input wire logic [1:0]  TEST_SELECT,
  input wire logic        FIFO_CLEAR
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  wire w0 = WR_STB && (WR_DATA[11:10] == `AMC_ADDR_CFG0);
  wire w1 = WR_STB && (WR_DATA[11:10] == `AMC_ADDR_CFG1);
  AST_PWR_DN: assert property (w0 |=> POWER_DOWN == $past(WR_DATA[`AMC_B_POWER]))
    else $error("Power down bit not applied");
  AST_TEST: assert property (w0 |=> TEST_SELECT == $past(WR_DATA[9:8]))
    else $error("Test field not applied");
  AST_POS: assert property (w0 && WR_DATA[7:3] == `AMC_CH_POS
    |=> SELECT_POSITIVE && !SELECT_NEGATIVE && !SELECT_DIFF) else $error("Bad input select");
  AST_HOLD: assert property (SAMPLE_HOLD == CONVERT_START &&
    (!SAMPLE_HOLD || $past(CONVERSION_CLOCK_IN, 3)))
    else $error("Hold and start differ");
  AST_PWR_DN_START: assert property (POWER_DOWN |-> !CONVERT_START)
    else $error("Start while powered down");
  AST_EDGE: assert property (CONVERT_START |-> !$past(CONVERSION_CLOCK_IN, 2))
    else $error("Start without falling pin");
  AST_PULSE: assert property (CONVERT_START |=> !CONVERT_START)
    else $error("Start longer than one cycle");
  AST_CLR: assert property (w1 && WR_DATA[`AMC_B_FIFO_CLR] |-> ##[1:2] FIFO_CLEAR)
    else $error("FIFO clear missing");
  AST_RSV: assert property (RD_STB && RD_ADDR[1] |=> RD_DATA == 10'h000)
    else $error("Reserved read not zero");
endmodule
bind amc_control amc_control_props u_props (.CLK(CLK), .RST_B(RST_B), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .WR_DATA(WR_DATA), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
  .CONVERSION_CLOCK_IN(CONVERSION_CLOCK_IN), .SAMPLE_HOLD(SAMPLE_HOLD),
  .CONVERT_START(CONVERT_START), .POWER_DOWN(POWER_DOWN), .SELECT_POSITIVE(SELECT_POSITIVE),
  .SELECT_NEGATIVE(SELECT_NEGATIVE), .SELECT_DIFF(SELECT_DIFF), .TEST_SELECT(TEST_SELECT),
  .FIFO_CLEAR(FIFO_CLEAR));
`default_nettype wire

// ==== testbench/amc_host.sv ====
// Purpose: Host processor model on the parallel bus
// Assumes: Drives everything at the falling clock edge
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module amc_host
(
  // Clock
  input wire logic       clk,
  // Register port
  output logic           wr_stb,
  output logic           rd_stb,
  output logic [11:0]    wr_data,
  output logic [1:0]     rd_addr,
  input wire logic [9:0] rd_data,
  // Conversion pin and FIFO side
  output logic           conv_pin,
  output logic           result,
  output logic           overrun
);
  initial
  begin
    {wr_stb, rd_stb, wr_data, rd_addr, result, overrun} = 18'h0;
    conv_pin = 1'b1;
  end
  task wr(input logic [1:0] a, input logic [9:0] v);
  begin
    @(negedge clk);
    wr_data = {a, v};
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    wr_data = ~wr_data;
  end
  endtask
  task rd(input logic [1:0] a, output logic [9:0] v);
  begin
    @(negedge clk);
    rd_stb = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_stb = 1'b0;
    rd_addr = ~a;
    @(negedge clk);
    v = rd_data;
  end
  endtask
  task strobe(input logic which);
  begin
    @(negedge clk);
    {overrun, result} = which ? 2'h2 : 2'h1;
    @(negedge clk);
    {overrun, result} = 2'h0;
  end
  endtask
  // Held low four cycles so the synchroniser surely sees it
  task start;
  begin
    @(negedge clk);
    conv_pin = 1'b0;
    repeat (4) @(negedge clk);
    conv_pin = 1'b1;
  end
  endtask
endmodule
`default_nettype wire

// ==== testbench/amc_control_tb.sv ====
// Purpose: Self-checking bench for amc_control
// Assumes: Host model drives the bus; 25 MHz clock
// Notes:   Scenarios run in order and share register state
`timescale 1ns/100ps
`default_nettype none
`include "amc_regs.vh"
module amc_control_tb;
  logic clk, rst_b;
  wire  wr_stb, rd_stb, pin, res, ovf, sh, cs, pwr, sp, sn, sd, scn, er, fc, dav;
  wire  [11:0] wd;
  wire  [1:0]  ra, ts;
  wire  [9:0]  rdd;
  logic [9:0]  v, starts, holds, n, m;
  int          num_errors, compares, i;
  localparam [19:0] CODES = {`AMC_CH_SCAN, `AMC_CH_DIFF, `AMC_CH_NEG, `AMC_CH_POS};
  // Expected {positive, negative, diff} per code; the pair selects both inputs
  localparam [8:0]  SELS  = {3'h7, 3'h2, 3'h4};
  amc_host u_host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wd), .rd_addr(ra),
    .rd_data(rdd), .conv_pin(pin), .result(res), .overrun(ovf));
  amc_control u_dut (.CLK(clk), .RST_B(rst_b), .WR_STB(wr_stb), .RD_STB(rd_stb), .WR_DATA(wd),
    .RD_ADDR(ra), .RD_DATA(rdd), .CONVERSION_CLOCK_IN(pin), .RESULT_WRITTEN(res),
    .OVERFLOW_IN(ovf), .SAMPLE_HOLD(sh), .CONVERT_START(cs), .POWER_DOWN(pwr),
    .SELECT_POSITIVE(sp), .SELECT_NEGATIVE(sn), .SELECT_DIFF(sd), .SCAN_NEGATIVE(scn),
    .TEST_SELECT(ts), .EXT_REFERENCE(er), .FIFO_CLEAR(fc), .DATA_AVAILABLE_OUT(dav));
  always @(posedge clk)
  begin
    if (rst_b !== 1'b1)
    begin
      starts <= 10'h0;
      holds  <= 10'h0;
    end
    else
    begin
      starts <= starts + {9'h0, cs === 1'b1};
      holds  <= holds + {9'h0, sh === 1'b1};
    end
  end
  task check(input logic [63:0] name, input logic [9:0] seen, input logic [9:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task test_done;
  begin
    $display("Mismatches %0d of %0d compares", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
  begin
    u_host.rd(`AMC_ADDR_CFG0, v);
    check("cfg0", v, `AMC_CFG0_RESET);
    u_host.rd(`AMC_ADDR_CFG1, v);
    check("cfg1", v, `AMC_CFG1_RESET);
    u_host.rd(2'h2, v);
    check("rsv", v, 10'h000);
    check("pwr0", {ts, pwr, er}, 4'h0);
  end
  endtask
  task t_select;
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      u_host.wr(`AMC_ADDR_CFG0, {i[1:0], CODES[i*5 +: 5], 2'h0, i[0]});
      check("test", ts, i[1:0]);
      check("vref", er, i[0]);
      if (i < 3)
        check("sel", {sp, sn, sd}, SELS[i*3 +: 3]);
    end
    check("scan0", {scn, sp, sn}, 3'h2);
    u_host.strobe(1'b0);
    check("scan1", {scn, sp, sn}, 3'h5);
  end
  endtask
  task t_power;
  begin
    u_host.wr(`AMC_ADDR_CFG0, 10'h006);
    u_host.rd(`AMC_ADDR_CFG0, v);
    check("pwr_rd", v, 10'h006);
    check("pwr1", pwr, 1'b1);
    n = starts;
    u_host.start;
    repeat (4) @(negedge clk);
    check("pwr_st", starts - n, 10'h0);
    u_host.wr(`AMC_ADDR_CFG0, 10'h002);
    m = holds;
    u_host.start;
    repeat (4) @(negedge clk);
    check("start", starts - n, 10'h1);
    check("hold", holds - m, 10'h1);
  end
  endtask
  task t_avail;
  begin
    u_host.wr(`AMC_ADDR_CFG1, 10'h024);
    repeat (3) u_host.strobe(1'b0);
    @(negedge clk);
    check("dav3", dav, 1'b0);
    u_host.strobe(1'b0);
    @(negedge clk);
    check("dav4", dav, 1'b1);
    u_host.strobe(1'b1);
    u_host.rd(`AMC_ADDR_CFG1, v);
    check("ovf", v, 10'h026);
    u_host.wr(`AMC_ADDR_CFG1, 10'h026);
    check("fclr", fc, 1'b1);
    repeat (2) @(negedge clk);
    check("davc", dav, 1'b0);
    check("fclr0", fc, 1'b0);
    u_host.wr(`AMC_ADDR_CFG1, 10'h010);
    check("davh", dav, 1'b1);
    u_host.strobe(1'b0);
    check("davp", dav, 1'b0);
    @(negedge clk);
    check("dave", dav, 1'b1);
  end
  endtask
  task t_soft;
  begin
    u_host.wr(`AMC_ADDR_CFG1, 10'h001);
    check("fclr1", fc, 1'b1);
    u_host.rd(`AMC_ADDR_CFG0, v);
    check("soft0", v, `AMC_CFG0_RESET);
    u_host.rd(`AMC_ADDR_CFG1, v);
    check("soft1", v, `AMC_CFG1_RESET);
    check("soft_sel", {sp, sn, sd}, 3'h7);
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    {num_errors, compares} = 64'h0;
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_reset;
    t_select;
    t_power;
    t_avail;
    t_soft;
    test_done;
  end
endmodule
`default_nettype wire
